// ### design/scsr_pkg.sv
/*
 * Shared constants and types for the spi control and status block:
 * register offsets, field positions, masks, reset values, divider
 * half-periods and the packed state record of the block.
 * Assumes a single 8-bit register port with a 3-bit word address.
 */
package scsr_pkg;

	// register offsets
	localparam logic [2:0] ADDR_CONTROL_A = 3'h0;
	localparam logic [2:0] ADDR_CONTROL_B = 3'h1;
	localparam logic [2:0] ADDR_INTERRUPT_ENABLES = 3'h2;
	localparam logic [2:0] ADDR_FLAGS = 3'h3;
	localparam logic [2:0] ADDR_DATA = 3'h4;

	// reset value, writable-bit masks and the normal-mode enables read mask
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] CONTROL_A_MASK = 8'h77;
	localparam logic [7:0] CONTROL_B_MASK = 8'hC7;
	localparam logic [7:0] INTERRUPT_ENABLES_MASK = 8'hF1;
	localparam logic [7:0] INTERRUPT_ENABLES_NORMAL_MASK = 8'h01;

	// control_a fields
	localparam int CA_ENABLE = 0;
	localparam int CA_CLOCK_DIVIDER_FIELD_LO = 1;
	localparam int CA_CLOCK_DIVIDER_FIELD_HI = 2;
	localparam int CA_CLOCK_DOUBLE = 4;
	localparam int CA_MASTER = 5;
	localparam int CA_BIT_ORDER = 6;

	// control_b fields
	localparam int CB_MODE_LO = 0;
	localparam int CB_MODE_HI = 1;
	localparam int CB_SELECT_IGNORE = 2;
	localparam int CB_WAIT_FOR_RECEIVE = 6;
	localparam int CB_BUFFERED = 7;

	// interrupt_enables fields
	localparam int IC_SINGLE = 0;
	localparam int IC_SELECT_TRIGGER = 4;
	localparam int IC_TX_EMPTY = 5;
	localparam int IC_TRANSFER_DONE = 6;
	localparam int IC_RECEIVE_DONE = 7;

	// flag layouts: normal and buffered
	localparam int FN_MAIN = 7;
	localparam int FN_WRITE_COLLISION = 6;
	localparam int FB_RECEIVE_DONE = 7;
	localparam int FB_TRANSFER_DONE = 6;
	localparam int FB_TX_EMPTY = 5;
	localparam int FB_SELECT_TRIGGER = 4;
	localparam int FB_OVERFLOW = 0;

	// divider encodings and half-periods in peripheral clocks
	localparam logic [1:0] DIVIDE_BY_FOUR = 2'h0;
	localparam logic [1:0] DIVIDE_BY_16 = 2'h1;
	localparam logic [1:0] DIVIDE_BY_64 = 2'h2;
	localparam logic [1:0] DIVIDE_BY_128 = 2'h3;
	localparam logic [6:0] HALF_DIVIDE_BY_FOUR = 7'h02;
	localparam logic [6:0] HALF_DIV16 = 7'h08;
	localparam logic [6:0] HALF_DIV64 = 7'h20;
	localparam logic [6:0] HALF_DIVIDE_BY_128 = 7'h40;

	// sixteen clock edges make one byte; receive queue holds two
	localparam logic [4:0] LAST_EDGE = 5'h0F;
	localparam logic [1:0] RX_FULL = 2'h2;

	typedef enum logic [0:0] {
		SCSR_IDLE,
		SCSR_RUN
	} scsr_phase_t;

	// complete state of the block, registered in one process
	typedef struct packed {
		logic [7:0] control_a;
		logic [7:0] control_b;
		logic [7:0] interrupt_enables;
		logic f_main;
		logic f_write_collision_flag;
		logic f_txdone;
		logic f_txempty;
		logic f_select;
		logic f_ovf;
		logic arm_main;
		logic arm_write_collision_flag;
		scsr_phase_t phase;
		logic [7:0] shreg;
		logic loaded;
		logic [7:0] txbuf;
		logic txfull;
		logic [7:0] rx_new;
		logic [7:0] rx_old;
		logic [1:0] rxcnt;
		logic [4:0] edges;
		logic [6:0] divcnt;
		logic sck;
		logic sdo;
		logic [2:0] sck_s;
		logic [2:0] mosi_s;
		logic [2:0] miso_s;
		logic [2:0] ss_s;
		logic sck_f;
		logic mosi_f;
		logic miso_f;
		logic ss_f;
		logic [7:0] rdata;
		logic irq;
		logic master_oe;
		logic miso_oe;
	} scsr_state_t;

endpackage

// ### design/scsr_top.sv
/*
 * Byte-wide spi peripheral with its control, configuration, interrupt
 * enable and flag registers; master or slave, normal or buffered mode.
 * Assumes one clock MCLK, synchronous active-high RESET, a register
 * port with single-cycle strobes, and pad logic that resolves the
 * three-signal pins (input, output, output enable) into wires.
 */
// What this block does
// [R1] bit order bit picks msb or lsb first
// [R2] select low demotes master, sets main flag (select flag when buffered)
// [R3] select ignore keeps master regardless of select
// [R4] clock double halves master half-period
// [R5] divider field gives 4,16,64,128 in master
// [R6] enable bit turns the peripheral on
// [R7] buffered mode adds queues and extra flags
// [R8] buffered without wait sends dummy first
// [R9] with wait, idle first write loads shifter
// [R10] mode field sets sample and setup edges
// [R11] clock idles at leading-edge opposite level
// [R12] buffered enables gate flags, else read zero
// [R13] normal mode single enable gates main flag
// [R14] main flag set after each full byte
// [R15] main flag cleared by ack or read-then-data
// [R16] data write during transfer sets collision
// [R17] collision cleared by flag read then data
// [R18] request held while flag and enable set
// [R19] third byte with full queue sets overflow
// [R20] tx empty set on move, cleared by write
// [R21] flag register layout follows buffered bit
// [R22] disabled: clock idles, nothing shifts
`timescale 1ns/1ps
module scsr_top (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// register port
	input wire logic [2:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// interrupt
	output logic IRQ,
	input wire logic IRQ_ACK,
	// serial pins
	input wire logic SCK_I,
	output logic SCK_O,
	output logic SCK_OE,
	input wire logic MOSI_I,
	output logic MOSI_O,
	output logic MOSI_OE,
	input wire logic MISO_I,
	output logic MISO_O,
	output logic MISO_OE,
	// select pin and its port direction
	input wire logic SS_N_I,
	input wire logic SS_DIR_IN
);

	scsr_pkg::scsr_state_t q;
	scsr_pkg::scsr_state_t n;

	logic enabled;
	logic master;
	logic buffered_mode_on;
	logic cpha;
	logic cpol;
	logic outbit;
	logic sdi;
	logic receive_done_flag;
	logic data_access;
	logic edge_now;
	logic sample;
	logic done;
	logic start;
	logic [6:0] half;
	logic [7:0] flags_rd;

	// flag readback and decode helpers
	always_comb begin
		enabled = q.control_a[scsr_pkg::CA_ENABLE];
		master = q.control_a[scsr_pkg::CA_MASTER];
		buffered_mode_on = q.control_b[scsr_pkg::CB_BUFFERED];
		cpha = q.control_b[scsr_pkg::CB_MODE_LO];
		cpol = q.control_b[scsr_pkg::CB_MODE_HI];
		receive_done_flag = (q.rxcnt != 2'h0);
		// msb first when order bit is 0, lsb first when 1
		outbit = q.control_a[scsr_pkg::CA_BIT_ORDER] ?
			q.shreg[0] : q.shreg[7]; // [R1]
		// the far side launches master data on our own clock edges, and
		// the filter lags past the shortest half-period: take the pin
		sdi = master ? MISO_I : q.mosi_f;
		flags_rd = scsr_pkg::REG_RESET;
		// one offset, two layouts chosen by the buffered bit
		if (buffered_mode_on) begin // [R21]
			flags_rd[scsr_pkg::FB_RECEIVE_DONE] = receive_done_flag;
			flags_rd[scsr_pkg::FB_TRANSFER_DONE] = q.f_txdone;
			flags_rd[scsr_pkg::FB_TX_EMPTY] = q.f_txempty;
			flags_rd[scsr_pkg::FB_SELECT_TRIGGER] = q.f_select;
			flags_rd[scsr_pkg::FB_OVERFLOW] = q.f_ovf;
		end else begin
			flags_rd[scsr_pkg::FN_MAIN] = q.f_main;
			flags_rd[scsr_pkg::FN_WRITE_COLLISION] = q.f_write_collision_flag;
		end
		// prescaler half-period, halved again by clock double
		case (q.control_a[scsr_pkg::CA_CLOCK_DIVIDER_FIELD_HI:scsr_pkg::CA_CLOCK_DIVIDER_FIELD_LO])
			scsr_pkg::DIVIDE_BY_FOUR: half = scsr_pkg::HALF_DIVIDE_BY_FOUR; // [R5]
			scsr_pkg::DIVIDE_BY_16: half = scsr_pkg::HALF_DIV16;
			scsr_pkg::DIVIDE_BY_64: half = scsr_pkg::HALF_DIV64;
			scsr_pkg::DIVIDE_BY_128: half = scsr_pkg::HALF_DIVIDE_BY_128;
			default: half = scsr_pkg::HALF_DIVIDE_BY_FOUR;
		endcase
		if (q.control_a[scsr_pkg::CA_CLOCK_DOUBLE]) begin
			half = half >> 1; // [R4]
		end
	end

	// next-state logic: register port first, hardware sets last so
	// an event in the same cycle as a clear is never lost
	always_comb begin
		n = q;
		edge_now = 1'b0;
		sample = 1'b0;
		done = 1'b0;
		start = 1'b0;
		data_access = (REG_WR || REG_RD) &&
			(REG_ADDR == scsr_pkg::ADDR_DATA);
		n.rdata = scsr_pkg::REG_RESET;

		// three-stage input filters: a level counts once the second and
		// third stages agree, which rejects single-cycle glitches
		n.sck_s = {q.sck_s[1:0], SCK_I};
		n.mosi_s = {q.mosi_s[1:0], MOSI_I};
		n.miso_s = {q.miso_s[1:0], MISO_I};
		n.ss_s = {q.ss_s[1:0], SS_N_I};
		if (q.sck_s[1] == q.sck_s[2]) begin
			n.sck_f = q.sck_s[2];
		end
		if (q.mosi_s[1] == q.mosi_s[2]) begin
			n.mosi_f = q.mosi_s[2];
		end
		if (q.miso_s[1] == q.miso_s[2]) begin
			n.miso_f = q.miso_s[2];
		end
		if (q.ss_s[1] == q.ss_s[2]) begin
			n.ss_f = q.ss_s[2];
		end

		// a data access clears the flags armed by an earlier flag read
		if (data_access) begin
			if (q.arm_main) begin
				n.f_main = 1'b0; // [R15]
			end
			if (q.arm_write_collision_flag) begin
				n.f_write_collision_flag = 1'b0; // [R17]
			end
			n.arm_main = 1'b0;
			n.arm_write_collision_flag = 1'b0;
		end
		if (IRQ_ACK) begin
			n.f_main = 1'b0; // [R15]
		end

		// register writes
		if (REG_WR) begin
			case (REG_ADDR)
				scsr_pkg::ADDR_CONTROL_A: begin
					n.control_a = REG_WDATA & scsr_pkg::CONTROL_A_MASK;
				end
				scsr_pkg::ADDR_CONTROL_B: begin
					n.control_b = REG_WDATA & scsr_pkg::CONTROL_B_MASK;
				end
				scsr_pkg::ADDR_INTERRUPT_ENABLES: begin
					n.interrupt_enables = REG_WDATA & scsr_pkg::INTERRUPT_ENABLES_MASK;
				end
				scsr_pkg::ADDR_FLAGS: begin
					// write-one-to-clear in the buffered layout only
					if (buffered_mode_on) begin
						if (REG_WDATA[scsr_pkg::FB_TRANSFER_DONE]) begin
							n.f_txdone = 1'b0;
						end
						if (REG_WDATA[scsr_pkg::FB_SELECT_TRIGGER]) begin
							n.f_select = 1'b0;
						end
						if (REG_WDATA[scsr_pkg::FB_RECEIVE_DONE]) begin
							n.rxcnt = 2'h0;
						end
					end
				end
				scsr_pkg::ADDR_DATA: begin
					if (!buffered_mode_on) begin
						// busy shifter: the write is dropped
						if (q.phase == scsr_pkg::SCSR_RUN) begin
							n.f_write_collision_flag = 1'b1; // [R16]
						end else begin
							n.shreg = REG_WDATA;
							n.loaded = 1'b1;
						end
					end else begin
						n.f_txempty = 1'b0; // [R20]
						if (q.control_b[scsr_pkg::CB_WAIT_FOR_RECEIVE] && enabled &&
							q.ss_f && q.phase == scsr_pkg::SCSR_IDLE &&
							!q.loaded && !q.txfull) begin
							n.shreg = REG_WDATA; // [R9]
							n.loaded = 1'b1;
						end else if (!q.txfull) begin
							n.txbuf = REG_WDATA; // [R7]
							n.txfull = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// register reads; data stands for one cycle only
		if (REG_RD) begin
			case (REG_ADDR)
				scsr_pkg::ADDR_CONTROL_A: n.rdata = q.control_a;
				scsr_pkg::ADDR_CONTROL_B: n.rdata = q.control_b;
				scsr_pkg::ADDR_INTERRUPT_ENABLES: begin
					// buffered enables read as zero outside buffered mode
					n.rdata = buffered_mode_on ? q.interrupt_enables :
						(q.interrupt_enables & scsr_pkg::INTERRUPT_ENABLES_NORMAL_MASK); // [R12]
				end
				scsr_pkg::ADDR_FLAGS: begin
					n.rdata = flags_rd;
					if (!buffered_mode_on) begin
						n.arm_main = q.f_main; // [R15]
						n.arm_write_collision_flag = q.f_write_collision_flag; // [R17]
					end
				end
				scsr_pkg::ADDR_DATA: begin
					if (buffered_mode_on) begin
						// oldest byte out, newer one moves up
						n.rdata = q.rx_old;
						n.rx_old = q.rx_new;
						n.f_ovf = 1'b0;
						if (q.rxcnt != 2'h0) begin
							n.rxcnt = q.rxcnt - 2'h1;
						end
					end else begin
						n.rdata = q.shreg;
					end
				end
				default: n.rdata = scsr_pkg::REG_RESET;
			endcase
		end

		// select low on an input pin demotes a master unless ignored
		if (enabled && master && SS_DIR_IN && !q.ss_f &&
			!q.control_b[scsr_pkg::CB_SELECT_IGNORE]) begin // [R3]
			n.control_a[scsr_pkg::CA_MASTER] = 1'b0; // [R2]
			if (buffered_mode_on) begin
				n.f_select = 1'b1;
			end else begin
				n.f_main = 1'b1; // [R2]
			end
			n.phase = scsr_pkg::SCSR_IDLE;
			n.edges = 5'h00;
			n.sck = cpol;
		end else if (!enabled) begin
			// off: clock parked at idle level, shifter frozen
			n.phase = scsr_pkg::SCSR_IDLE; // [R22]
			n.edges = 5'h00;
			n.divcnt = 7'h00;
			n.sck = cpol; // [R6]
		end else if (master) begin
			case (q.phase)
				scsr_pkg::SCSR_IDLE: begin
					n.sck = cpol; // [R11]
					// buffered, no wait: a queued byte starts a dummy
					start = q.loaded || (buffered_mode_on && q.txfull); // [R8]
					if (start) begin
						n.phase = scsr_pkg::SCSR_RUN;
						n.edges = 5'h00;
						n.divcnt = 7'h00;
						if (!cpha) begin
							n.sdo = outbit;
						end
					end
				end
				scsr_pkg::SCSR_RUN: begin
					n.divcnt = q.divcnt + 7'h01;
					if (q.divcnt + 7'h01 >= half) begin
						n.divcnt = 7'h00;
						n.sck = ~q.sck;
						edge_now = 1'b1;
					end
				end
				default: n.phase = scsr_pkg::SCSR_IDLE;
			endcase
		end else begin
			// slave: select high halts and resynchronises the counter
			n.divcnt = 7'h00;
			n.sck = cpol; // [R11]
			if (q.ss_f) begin
				n.phase = scsr_pkg::SCSR_IDLE;
				n.edges = 5'h00;
			end else begin
				n.phase = scsr_pkg::SCSR_RUN;
				if (!cpha && q.edges == 5'h00) begin
					n.sdo = outbit;
				end
				if (n.sck_f != q.sck_f) begin
					edge_now = 1'b1;
				end
			end
		end

		// edge action: even edges lead; mode 0 and 2 sample on leading
		if (edge_now) begin
			sample = (q.edges[0] == cpha); // [R10]
			if (sample) begin
				if (q.control_a[scsr_pkg::CA_BIT_ORDER]) begin
					n.shreg = {sdi, q.shreg[7:1]}; // [R1]
				end else begin
					n.shreg = {q.shreg[6:0], sdi};
				end
			end else begin
				n.sdo = outbit;
			end
			n.edges = q.edges + 5'h01;
			if (q.edges == scsr_pkg::LAST_EDGE) begin
				done = 1'b1;
				n.edges = 5'h00;
				if (master) begin
					n.phase = scsr_pkg::SCSR_IDLE;
				end
			end
		end

		// byte complete
		if (done) begin
			n.loaded = 1'b0;
			if (!buffered_mode_on) begin
				n.f_main = 1'b1; // [R14]
			end else begin
				// queue full: the new byte is lost and flagged
				if (q.rxcnt == scsr_pkg::RX_FULL) begin
					n.f_ovf = 1'b1; // [R19]
				end else if (n.rxcnt == 2'h0) begin
					n.rx_old = n.shreg;
					n.rxcnt = 2'h1;
				end else begin
					n.rx_new = n.shreg;
					n.rxcnt = scsr_pkg::RX_FULL;
				end
				if (n.txfull) begin
					n.shreg = n.txbuf;
					n.txfull = 1'b0;
					n.loaded = 1'b1;
					n.f_txempty = 1'b1; // [R20]
				end else begin
					n.f_txdone = 1'b1; // [R7]
				end
			end
		end

		// request stands while any enabled flag stands
		if (n.control_b[scsr_pkg::CB_BUFFERED]) begin
			n.irq = (n.interrupt_enables[scsr_pkg::IC_RECEIVE_DONE] &&
				n.rxcnt != 2'h0) ||
				(n.interrupt_enables[scsr_pkg::IC_TRANSFER_DONE] && n.f_txdone) ||
				(n.interrupt_enables[scsr_pkg::IC_TX_EMPTY] && n.f_txempty) ||
				(n.interrupt_enables[scsr_pkg::IC_SELECT_TRIGGER] &&
				n.f_select); // [R12] [R18]
		end else begin
			n.irq = n.interrupt_enables[scsr_pkg::IC_SINGLE] && n.f_main; // [R13]
		end

		// pin drivers
		n.master_oe = n.control_a[scsr_pkg::CA_ENABLE] &&
			n.control_a[scsr_pkg::CA_MASTER];
		n.miso_oe = n.control_a[scsr_pkg::CA_ENABLE] &&
			!n.control_a[scsr_pkg::CA_MASTER] && !n.ss_f;
	end

	// the single state register
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// outputs straight from the state register
	assign REG_RDATA = q.rdata;
	assign IRQ = q.irq;
	assign SCK_O = q.sck;
	assign SCK_OE = q.master_oe;
	assign MOSI_O = q.sdo;
	assign MOSI_OE = q.master_oe;
	assign MISO_O = q.sdo;
	assign MISO_OE = q.miso_oe;

endmodule

// ### tb/scsr_assertions.sv
/*
 * Port-level checker for the spi control and status block.
 * Assumes one clock MCLK and synchronous active-high RESET.
 */
`timescale 1ns/1ps
module scsr_checker (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// register port
	input wire logic [2:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	// serial outputs
	input wire logic SCK_O,
	input wire logic SCK_OE,
	input wire logic MOSI_O,
	input wire logic MOSI_OE,
	input wire logic MISO_O,
	input wire logic MISO_OE
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	// control_a writes that switch a master on or the block off
	sequence s_enable_wr;
		REG_WR && REG_ADDR == 3'h0 && REG_WDATA[0] && REG_WDATA[5];
	endsequence
	sequence s_disable_wr;
		REG_WR && REG_ADDR == 3'h0 && !REG_WDATA[0];
	endsequence

	a_read_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("read data outside a read answer");
	a_unmapped_rd: assert property (REG_RD && REG_ADDR > 3'h4 |=>
		REG_RDATA == 8'h00) else $error("unmapped read not zero");
	a_control_a_rsv: assert property (REG_RD && REG_ADDR == 3'h0 |=>
		(REG_RDATA & 8'h88) == 8'h00) else $error("control_a spare bits");
	a_control_b_rsv: assert property (REG_RD && REG_ADDR == 3'h1 |=>
		(REG_RDATA & 8'h38) == 8'h00) else $error("control_b spare bits");
	a_master_on: assert property (s_enable_wr |-> ##[1:2] SCK_OE)
		else $error("master outputs not enabled");
	a_master_off: assert property (s_disable_wr |-> ##[1:2] !SCK_OE)
		else $error("outputs still enabled");
	// idle clock may only move when a control write changed its level
	a_sck_still: assert property (!SCK_OE && !$past(SCK_OE) &&
		$changed(SCK_O) |-> $past(REG_WR) || $past(REG_WR, 2) ||
		$past(REG_WR, 3)) else $error("clock moved while disabled");
	a_oe_pair: assert property (SCK_OE == MOSI_OE)
		else $error("clock and data enables differ");
	a_one_driver: assert property (SCK_OE |-> !MISO_OE)
		else $error("master drives slave line");
	a_data_same: assert property (MISO_O == MOSI_O)
		else $error("data outputs differ");
	// a mode write while the clock output is off parks the clock at the new level
	a_idle_level: assert property (REG_WR && REG_ADDR == 3'h1 && !SCK_OE
		|-> ##2 SCK_O == $past(REG_WDATA[1], 2))
		else $error("clock idle level wrong");
endmodule

bind scsr_top scsr_checker u_chk (.MCLK(MCLK), .RESET(RESET),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SCK_O(SCK_O), .SCK_OE(SCK_OE),
	.MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE), .MISO_O(MISO_O), .MISO_OE(MISO_OE));

// ### tb/scsr_slave_model.sv
/*
 * Behavioural spi slave facing the block in master mode.
 * Assumes the clock only moves inside frames while en is high.
 */
`timescale 1ns/1ps
module scsr_slave_model (
	// serial lines
	input wire logic sck,
	input wire logic en,
	input wire logic mosi,
	output logic miso,
	// configuration and data
	input wire logic [1:0] mode,
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic done
);
	int edges = 0;
	logic last = 1'b0;
	initial begin
		miso = 1'b0;
		rx_byte = 8'h00;
		done = 1'b0;
	end
	// sample and setup edges from the mode; outside frames phase-one
	// mode keeps flipping the line so a stale bit is never kind
	always @(sck, en, tx_byte, mode) begin
		if (en !== 1'b1 || sck === last) begin
			if (en !== 1'b1)
				edges = 0;
			if (edges == 0)
				miso = mode[0] ? ~miso : tx_byte[7];
		end else begin
			edges++;
			if (edges[0] ^ mode[0])
				rx_byte = {rx_byte[6:0], mosi};
			else if (edges < 16)
				miso = tx_byte[7 - edges / 2];
			if (edges == 16) begin
				edges = 0;
				done = ~done;
				// phase-zero modes need the first bit up before the next
				// frame, which may follow with no idle gap
				if (!mode[0])
					miso = tx_byte[7];
			end
		end
		last = sck;
	end
endmodule

// ### tb/tb.sv
/*
 * Self-checking bench for the spi control and status block.
 * Assumes the design package is compiled first and the slave model
 * answers on the master lines.
 */
`timescale 1ns/1ps
module tb;
	logic MCLK = 1'b0;
	logic RESET = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0, ack = 1'b0;
	logic ss_n = 1'b1, ss_dir = 1'b0, p_sck = 1'b0;
	logic irq, sck, sck_oe, mosi, mosi_oe, miso, miso_o, miso_oe, done;
	logic [1:0] mode = 2'h0;
	logic [7:0] tx = 8'h00, rdata, srx;
	logic [7:0] q[$];
	int n_errors = 0, check_count = 0, cyc = 0, last_t = 0, half = 0;
	int tog = 0, seed = 32'h6d5cab52;
	int hp[4] = '{2, 8, 32, 64};

	scsr_top DUT (.MCLK(MCLK), .RESET(RESET), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.IRQ(irq), .IRQ_ACK(ack), .SCK_I(1'b0), .SCK_O(sck), .SCK_OE(sck_oe),
		.MOSI_I(1'b0), .MOSI_O(mosi), .MOSI_OE(mosi_oe), .MISO_I(miso),
		.MISO_O(miso_o), .MISO_OE(miso_oe), .SS_N_I(ss_n),
		.SS_DIR_IN(ss_dir));
	scsr_slave_model u_slave (.sck(sck), .en(sck_oe), .mosi(mosi),
		.miso(miso), .mode(mode), .tx_byte(tx), .rx_byte(srx), .done(done));

	initial forever #4 MCLK = ~MCLK;

	task automatic report_and_stop();
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] want);
		check_count++;
		if (got !== want) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge MCLK);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge MCLK);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
		@(posedge MCLK);
		addr <= a;
		rd <= 1'b1;
		q.push_back(e);
		@(posedge MCLK);
		rd <= 1'b0;
	endtask
	// bounded wait for n frames seen by the slave, then let flags land
	task automatic wait_frames(input int n);
		logic d0;
		for (int k = 0; k < n; k++) begin
			d0 = done;
			for (int c = 0; c < 3000 && done === d0; c++)
				@(posedge MCLK);
		end
		repeat (6) @(posedge MCLK);
	endtask
	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int k = 0; k < 8; k++)
			rev[k] = v[7 - k];
	endfunction

	// read answers are due in the cycle after the strobe only
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		rd_d <= rd;
		p_sck <= sck;
		if (rd_d)
			check(rdata, q.pop_front());
		if (sck !== p_sck) begin
			half <= cyc - last_t;
			last_t <= cyc;
			tog <= tog + 1;
		end
	end

	initial begin
		logic [7:0] b;
		logic [2:0] i3;
		int t0;
		repeat (5) @(posedge MCLK);
		RESET <= 1'b0;
		for (int a = 0; a < 6; a++)
			rd_reg(3'(a), 8'h00);
		// read masks; buffered enables read back only in buffered mode
		wr_reg(3'h1, 8'hFF);
		wr_reg(3'h2, 8'hFF);
		rd_reg(3'h1, 8'hC7);
		rd_reg(3'h2, 8'hF1);
		wr_reg(3'h1, 8'h00);
		wr_reg(3'h5, 8'hFF);
		rd_reg(3'h2, 8'h01);
		rd_reg(3'h0, 8'h00);
		// every mode, divider, doubling and bit order in one sweep
		for (int i = 0; i < 8; i++) begin
			i3 = 3'(i);
			b = 8'($random(seed));
			tx <= 8'($random(seed));
			mode <= i3[1:0];
			wr_reg(3'h0, 8'h00);
			wr_reg(3'h1, {6'h00, i3[1:0]});
			wr_reg(3'h0, {1'b0, i3[2], 1'b1, i3[0], 1'b0, i3[2:1], 1'b1});
			repeat (3) @(posedge MCLK);
			check({7'h00, sck}, {7'h00, i3[1]});
			wr_reg(3'h4, b);
			if (i == 3) begin
				repeat (4) @(posedge MCLK);
				wr_reg(3'h4, ~b);
			end
			wait_frames(1);
			check(srx, i3[2] ? rev(b) : b);
			check(8'(half), 8'(hp[i3[2:1]] >> i3[0]));
			check({7'h00, irq}, 8'h01);
			if (i == 5) begin
				ack <= 1'b1;
				@(posedge MCLK);
				ack <= 1'b0;
			end
			rd_reg(3'h3, i == 3 ? 8'hC0 : i == 5 ? 8'h00 : 8'h80);
			rd_reg(3'h4, i3[2] ? rev(tx) : tx);
			rd_reg(3'h3, 8'h00);
			repeat (2) @(posedge MCLK);
			check({7'h00, irq}, 8'h00);
		end
		// select low demotes a master unless the select line is ignored
		ss_dir <= 1'b1;
		wr_reg(3'h1, 8'h04);
		wr_reg(3'h0, 8'h21);
		ss_n <= 1'b0;
		repeat (8) @(posedge MCLK);
		rd_reg(3'h0, 8'h21);
		wr_reg(3'h1, 8'h00);
		repeat (8) @(posedge MCLK);
		rd_reg(3'h0, 8'h01);
		rd_reg(3'h3, 8'h80);
		ss_n <= 1'b1;
		ss_dir <= 1'b0;
		ack <= 1'b1;
		@(posedge MCLK);
		ack <= 1'b0;
		// a disabled master must not clock out a written byte
		wr_reg(3'h0, 8'h20);
		t0 = tog;
		wr_reg(3'h4, 8'h5A);
		repeat (40) @(posedge MCLK);
		check(8'(tog - t0), 8'h00);
		check({7'h00, sck_oe}, 8'h00);
		// buffered without waiting: the 5A left loaded by the disabled write goes out first, then the byte
		mode <= 2'h0;
		wr_reg(3'h1, 8'h80);
		wr_reg(3'h0, 8'h21);
		b = 8'($random(seed));
		wr_reg(3'h4, b);
		wait_frames(2);
		check(srx, b);
		rd_reg(3'h3, 8'hE0);
		// waiting for receive: an idle write loads the shifter at once;
		// the queue already holds two bytes, so this one overflows
		b = 8'($random(seed));
		wr_reg(3'h1, 8'hC0);
		wr_reg(3'h4, b);
		wait_frames(1);
		check(srx, b);
		check({7'h00, irq}, 8'h01);
		rd_reg(3'h3, 8'hC1);
		rd_reg(3'h4, tx);
		rd_reg(3'h3, 8'hC0);
		repeat (4) @(posedge MCLK);
		report_and_stop();
	end

	// watchdog well beyond the longest sweep
	initial begin
		repeat (60000) @(posedge MCLK);
		n_errors++;
		report_and_stop();
	end
endmodule
